// >>> asc_cfg.svh
// Purpose: Constants for the analog speed command select block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_OFF_INSEL      12'h000
`define ASC_OFF_MODE2      12'h004
`define ASC_OFF_THERM      12'h008
`define ASC_OFF_EXTDISP    12'h00c
`define ASC_OFF_ASSIGN     12'h010
`define ASC_OFF_GAIN1      12'h014
`define ASC_OFF_GAIN2      12'h018
`define ASC_OFF_SAMPLE1    12'h01c
`define ASC_OFF_SAMPLE2    12'h020
`define ASC_OFF_STATUS     12'h024
`define ASC_OFF_CMD        12'h028
`define ASC_RST_INSEL      8'h01
`define ASC_RST_MODE2      2'h0
`define ASC_RST_THERM      16'h270f
`define ASC_RST_EXTDISP    8'h00
`define ASC_RST_ASSIGN     40'h0000000000
`define ASC_RST_GAIN       16'h1770
`define ASC_THERM_OFF      16'h270f
`define ASC_ASSIGN_AU      8'h04
`define ASC_SEL_10V        8'h00
`define ASC_SEL_5V         8'h01
`define ASC_SEL_10V_REV    8'h0a
`define ASC_SEL_5V_REV     8'h0b
`define ASC_FS_5V          12'h7ff
`define ASC_FS_10V         12'hfff
`define ASC_I4MA           12'h333
`define ASC_ASSIGN_N       5
`endif

// >>> asc_pkg.sv
// Purpose: Types for the analog speed command select block.
// Assumes: Nothing beyond the configuration header.
// Notes:   None.
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_SRC_NONE = 2'b00,
    ASC_SRC_V1   = 2'b01,
    ASC_SRC_IN2  = 2'b10
  } asc_src_t;
  typedef enum logic [1:0] {
    ASC_M2_CUR  = 2'b00,
    ASC_M2_V5   = 2'b01,
    ASC_M2_V10  = 2'b10
  } asc_mode2_t;
endpackage

// >>> asc_select.sv
// Purpose: Chooses and scales the analog speed command of a motor drive.
// Assumes: 12-bit samples where 12'hfff is 10 V or 20 mA on the input pins.
// Notes:   Settings are reached over APB; the result is a signed frequency.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "asc_cfg.svh"

module asc_select
(
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Input terminals and converter samples.
  input  wire logic [4:0]            term_in,
  input  wire logic                  switch_voltage,
  input  wire logic [11:0]           sample_v1,
  input  wire logic [11:0]           sample_in2,
  // Command result.
  output logic signed [16:0]         freq_cmd,
  output asc_pkg::asc_src_t          cmd_source,
  output logic                       reverse_cmd
);
  import asc_pkg::*;

  logic             rst_meta_r;
  logic             rst_n_r;
  logic [4:0]       term_m_r;
  logic [4:0]       term_s_r;
  logic             sw_m_r;
  logic             sw_s_r;
  logic [7:0]       insel_r, insel_nxt;
  logic [1:0]       mode2_r, mode2_nxt;
  logic [15:0]      therm_r, therm_nxt;
  logic [7:0]       extdisp_r, extdisp_nxt;
  logic [39:0]      assign_r, assign_nxt;
  logic [15:0]      gain1_r, gain1_nxt;
  logic [15:0]      gain2_r, gain2_nxt;
  logic [31:0]      prdata_r, prdata_nxt;
  logic signed [16:0] cmd_r, cmd_nxt;
  asc_src_t         src_r, src_nxt;
  logic [4:0]       au_hit;
  logic             au_on;
  logic             v1_ok;
  logic             rev_en;
  logic [11:0]      lvl;
  logic [11:0]      fs;
  logic [11:0]      mid;
  logic             use_in2;
  logic             in2_volt;
  logic             wr_acc;
  logic             wr_cfg;
  logic [28:0]      prod;
  logic [15:0]      mag;

  // Reset release through two flops.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Terminal and switch inputs pass two flops before use; the converter samples are used directly.
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      term_m_r <= 5'h00;
      term_s_r <= 5'h00;
      sw_m_r   <= 1'b0;
      sw_s_r   <= 1'b0;
    end
    else
    begin
      term_m_r <= term_in;
      term_s_r <= term_m_r;
      sw_m_r   <= switch_voltage;
      sw_s_r   <= sw_m_r;
    end
  end

  // Any terminal whose assignment holds the enable code carries it.
  genvar gi;
  generate
    for (gi = 0; gi < `ASC_ASSIGN_N; gi = gi + 1)
    begin : g_assign
      assign au_hit[gi] = (assign_r[gi*8 +: 8] == `ASC_ASSIGN_AU) && term_s_r[gi];
    end
  endgenerate
  assign au_on = |au_hit;

  assign wr_acc = psel && penable && pwrite;
  assign wr_cfg = wr_acc && (extdisp_r == 8'h00);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Register writes.
  always_comb
  begin
    insel_nxt   = insel_r;
    mode2_nxt   = mode2_r;
    therm_nxt   = therm_r;
    extdisp_nxt = extdisp_r;
    assign_nxt  = assign_r;
    gain1_nxt   = gain1_r;
    gain2_nxt   = gain2_r;
    if (wr_acc && paddr == `ASC_OFF_EXTDISP)
      extdisp_nxt = pwdata[7:0];
    if (wr_cfg)
    begin
      case (paddr)
        `ASC_OFF_INSEL:
        begin
          // Only documented codes are taken; ramp timing lives elsewhere and is untouched.
          if (pwdata[7:0] == `ASC_SEL_10V || pwdata[7:0] == `ASC_SEL_5V ||
              pwdata[7:0] == `ASC_SEL_10V_REV || pwdata[7:0] == `ASC_SEL_5V_REV)
            insel_nxt = pwdata[7:0];
        end
        `ASC_OFF_MODE2:
        begin
          if (pwdata[1:0] != 2'h3)
            mode2_nxt = pwdata[1:0];
        end
        `ASC_OFF_THERM:  therm_nxt  = pwdata[15:0];
        `ASC_OFF_ASSIGN: assign_nxt = {assign_r[39:32], pwdata[31:0]};
        // Terminal 4 needs a fifth byte, so it is written where it is read back.
        `ASC_OFF_SAMPLE1: assign_nxt = {pwdata[7:0], assign_r[31:0]};
        `ASC_OFF_GAIN1:  gain1_nxt  = pwdata[15:0];
        `ASC_OFF_GAIN2:  gain2_nxt  = pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data, unmapped reads return zero.
  always_comb
  begin
    prdata_nxt = 32'h0;
    case (paddr)
      `ASC_OFF_INSEL:   prdata_nxt = {24'h0, insel_r};
      `ASC_OFF_MODE2:   prdata_nxt = {30'h0, mode2_r};
      `ASC_OFF_THERM:   prdata_nxt = {16'h0, therm_r};
      `ASC_OFF_EXTDISP: prdata_nxt = {24'h0, extdisp_r};
      `ASC_OFF_ASSIGN:  prdata_nxt = assign_r[31:0];
      `ASC_OFF_GAIN1:   prdata_nxt = {16'h0, gain1_r};
      `ASC_OFF_GAIN2:   prdata_nxt = {16'h0, gain2_r};
      `ASC_OFF_SAMPLE1: prdata_nxt = {24'h0, assign_r[39:32]};
      `ASC_OFF_STATUS:  prdata_nxt = {26'h0, reverse_cmd, sw_s_r, au_on, v1_ok, src_r};
      `ASC_OFF_CMD:     prdata_nxt = {{15{cmd_r[16]}}, cmd_r};
      default:          prdata_nxt = 32'h0;
    endcase
  end
  assign prdata = prdata_r;

  // Source selection and scaling.
  assign v1_ok    = (therm_r == `ASC_THERM_OFF);
  assign in2_volt = (mode2_r != ASC_M2_CUR) && sw_s_r;
  assign use_in2  = au_on;
  assign rev_en   = insel_r[3];
  always_comb
  begin
    src_nxt = ASC_SRC_NONE;
    lvl     = 12'h000;
    fs      = `ASC_FS_10V;
    mid     = 12'h000;
    if (use_in2)
    begin
      src_nxt = ASC_SRC_IN2;
      lvl     = sample_in2;
      if (in2_volt && mode2_r == ASC_M2_V5)
        fs = `ASC_FS_5V;
      // Reversal pivots at 4 mA on current, at half scale on voltage.
      mid = in2_volt ? {1'b0, fs[11:1]} : `ASC_I4MA;
    end
    else if (v1_ok)
    begin
      src_nxt = ASC_SRC_V1;
      lvl     = sample_v1;
      fs      = insel_r[0] ? `ASC_FS_5V : `ASC_FS_10V;
      mid     = {1'b0, fs[11:1]};
    end
  end

  always_comb
  begin
    cmd_nxt = 17'sh0;
    prod    = 29'h0;
    mag     = 16'h0;
    if (src_nxt != ASC_SRC_NONE)
    begin
      if (rev_en && lvl < mid)
      begin
        prod    = (29'(mid - lvl)) * 29'(src_nxt == ASC_SRC_IN2 ? gain2_r : gain1_r);
        mag     = 16'(prod / 29'(mid == 12'h0 ? 12'h1 : mid));
        cmd_nxt = -$signed({1'b0, mag});
      end
      else
      begin
        if (lvl >= fs)
          mag = src_nxt == ASC_SRC_IN2 ? gain2_r : gain1_r;
        else if (rev_en)
        begin
          prod = (29'(lvl - mid)) * 29'(src_nxt == ASC_SRC_IN2 ? gain2_r : gain1_r);
          mag  = 16'(prod / 29'(fs - mid));
        end
        else
        begin
          prod = 29'(lvl) * 29'(src_nxt == ASC_SRC_IN2 ? gain2_r : gain1_r);
          mag  = 16'(prod / 29'(fs));
        end
        cmd_nxt = $signed({1'b0, mag});
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      insel_r   <= `ASC_RST_INSEL;
      mode2_r   <= `ASC_RST_MODE2;
      therm_r   <= `ASC_RST_THERM;
      extdisp_r <= `ASC_RST_EXTDISP;
      assign_r  <= `ASC_RST_ASSIGN;
      gain1_r   <= `ASC_RST_GAIN;
      gain2_r   <= `ASC_RST_GAIN;
      prdata_r  <= 32'h0;
      cmd_r     <= 17'sh0;
      src_r     <= ASC_SRC_NONE;
    end
    else
    begin
      insel_r   <= insel_nxt;
      mode2_r   <= mode2_nxt;
      therm_r   <= therm_nxt;
      extdisp_r <= extdisp_nxt;
      assign_r  <= assign_nxt;
      gain1_r   <= gain1_nxt;
      gain2_r   <= gain2_nxt;
      prdata_r  <= prdata_nxt;
      cmd_r     <= cmd_nxt;
      src_r     <= src_nxt;
    end
  end

  assign freq_cmd    = cmd_r;
  assign cmd_source  = src_r;
  assign reverse_cmd = cmd_r[16];

  chk_fwd_only_sign: assert property (@(posedge clock) disable iff (!rst_n_r)
    !insel_r[3] && !$past(insel_r[3]) |-> !cmd_r[16]) else $error("Negative command without reverse.");
  chk_therm_block: assert property (@(posedge clock) disable iff (!rst_n_r)
    $past(therm_r) != `ASC_THERM_OFF |-> src_r != ASC_SRC_V1) else $error("Voltage input used while blocked.");
  chk_in2_gate: assert property (@(posedge clock) disable iff (!rst_n_r)
    src_r == ASC_SRC_IN2 |-> $past(au_on)) else $error("Second input used while disabled.");
  chk_cfg_lock: assert property (@(posedge clock) disable iff (!rst_n_r)
    $past(extdisp_r) != 8'h00 |-> $stable(insel_r) && $stable(mode2_r)) else $error("Locked setting changed.");
  chk_insel_codes: assert property (@(posedge clock) disable iff (!rst_n_r)
    insel_r == `ASC_SEL_5V || insel_r == `ASC_SEL_10V ||
    insel_r == `ASC_SEL_10V_REV || insel_r == `ASC_SEL_5V_REV) else $error("Bad select code.");
  chk_full_scale: assert property (@(posedge clock) disable iff (!rst_n_r)
    src_nxt == ASC_SRC_V1 && lvl >= fs |=> cmd_r == $signed({1'b0, $past(gain1_r)})) else $error("Full scale not max.");
  chk_assign_map: assert property (@(posedge clock) disable iff (!rst_n_r)
    au_on |-> |(term_s_r)) else $error("Enable without terminal.");
  chk_mode_legal: assert property (@(posedge clock) disable iff (!rst_n_r)
    mode2_r != 2'h3) else $error("Illegal second input mode.");
  chk_v1_default: assert property (@(posedge clock) disable iff (!rst_n_r)
    $past(rst_n_r) && $past(v1_ok) && !$past(au_on) |-> src_r == ASC_SRC_V1) else $error("Voltage input not default.");
  chk_rev_pivot: assert property (@(posedge clock) disable iff (!rst_n_r)
    src_nxt == ASC_SRC_IN2 && !in2_volt && rev_en && lvl == `ASC_I4MA |=> cmd_r == 17'sh0) else $error("Pivot not zero.");
  chk_cfg_open: assert property (@(posedge clock) disable iff (!rst_n_r)
    wr_acc && paddr == `ASC_OFF_INSEL && extdisp_r == 8'h00 && pwdata[7:0] == `ASC_SEL_10V |=>
    insel_r == `ASC_SEL_10V) else $error("Open select write lost.");
endmodule // asc_select

// >>> asc_src_model.sv
// Purpose: Far side of the speed command block: analog sources and input terminals.
// Assumes: The bench sets the wanted levels; they reach the pins at the next rising edge.
// Notes:   The switch position always follows the second input mode.
`timescale 1ns/100ps

module asc_src_model
(
  // Clock and commanded levels.
  input  wire logic        clock,
  input  wire logic [1:0]  mode,
  input  wire logic [4:0]  term_lvl,
  input  wire logic [11:0] v1_lvl,
  input  wire logic [11:0] in2_lvl,
  // Pins towards the block.
  output logic      [4:0]  term_in,
  output logic             switch_voltage,
  output logic      [11:0] sample_v1,
  output logic      [11:0] sample_in2
);
  always_ff @(posedge clock)
  begin
    term_in        <= term_lvl;
    switch_voltage <= (mode != 2'h0);
    sample_v1      <= v1_lvl;
    sample_in2     <= in2_lvl;
  end
endmodule // asc_src_model

// >>> testbench.sv
// Purpose: Self-checking bench for the analog speed command select block.
// Assumes: Zero-wait APB slave; commands settle within a few cycles of a change.
// Notes:   GAIN1 values are drawn at random from a fixed seed; GAIN2 keeps its reset value.
`timescale 1ns/100ps
`include "asc_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  import asc_pkg::*;
  logic               clock, arst_n, psel, penable, pwrite, pready, pslverr, reverse_cmd, switch_voltage;
  logic        [11:0] paddr, v1, in2, sample_v1, sample_in2;
  logic        [31:0] pwdata, prdata, rd, seed, gain;
  logic        [4:0]  term_in, tl;
  logic        [1:0]  mode;
  logic signed [16:0] freq_cmd;
  asc_src_t           cmd_source;
  logic        [7:0]  sel [4] = '{8'h00, 8'h01, 8'h0a, 8'h0b};
  int                 n_errors, checks, cyc;

  asc_select asc_select_inst (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .term_in(term_in),
    .switch_voltage(switch_voltage), .sample_v1(sample_v1), .sample_in2(sample_in2), .freq_cmd(freq_cmd),
    .cmd_source(cmd_source), .reverse_cmd(reverse_cmd));
  asc_src_model asc_src_model_inst (.clock(clock), .mode(mode), .term_lvl(tl), .v1_lvl(v1), .in2_lvl(in2),
    .term_in(term_in), .switch_voltage(switch_voltage), .sample_v1(sample_v1), .sample_in2(sample_in2));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic complete_run();
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // One APB transfer, entered just after a rising edge; read data lands in rd.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    `CHK(pslverr, 1'b0)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chkrd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic cmd(input logic signed [16:0] f, input asc_src_t s, input logic r);
    repeat (6) @(posedge clock);
    `CHK(freq_cmd, f)
    `CHK(cmd_source, s)
    `CHK(reverse_cmd, r)
  endtask

  initial
  begin
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, tl, v1, in2, mode} = '0;
    seed = 32'ha6153df4;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chkrd(`ASC_OFF_INSEL, 32'(`ASC_RST_INSEL));
    chkrd(`ASC_OFF_MODE2, 32'(`ASC_RST_MODE2));
    chkrd(`ASC_OFF_THERM, 32'(`ASC_RST_THERM));
    chkrd(`ASC_OFF_EXTDISP, 32'h0);
    chkrd(`ASC_OFF_GAIN2, 32'(`ASC_RST_GAIN));
    chkrd(12'h030, 32'h0);
    cmd(17'sh0, ASC_SRC_V1, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      gain = 32'd1 + seed % 32'd40000;
      wr(`ASC_OFF_INSEL, 32'(sel[k]));
      wr(`ASC_OFF_GAIN1, gain);
      v1 <= sel[k][0] ? `ASC_FS_5V : `ASC_FS_10V;
      cmd(17'(gain), ASC_SRC_V1, 1'b0);
      v1 <= 12'h000;
      cmd(sel[k][3] ? -17'(gain) : 17'sh0, ASC_SRC_V1, sel[k][3]);
    end
    wr(`ASC_OFF_INSEL, 32'h5);
    chkrd(`ASC_OFF_INSEL, 32'h0b);
    wr(`ASC_OFF_EXTDISP, 32'h1);
    wr(`ASC_OFF_INSEL, 32'h1);
    chkrd(`ASC_OFF_INSEL, 32'h0b);
    wr(`ASC_OFF_EXTDISP, 32'h0);
    wr(`ASC_OFF_INSEL, 32'h1);
    chkrd(`ASC_OFF_INSEL, 32'h1);
    wr(`ASC_OFF_ASSIGN, 32'h00040000);
    tl <= 5'h01;
    in2 <= 12'hfff;
    cmd(17'sh0, ASC_SRC_V1, 1'b0);
    tl <= 5'h05;
    cmd(17'sd6000, ASC_SRC_IN2, 1'b0);
    chkrd(`ASC_OFF_STATUS, 32'h0e);
    chkrd(`ASC_OFF_CMD, 32'h1770);
    for (int m = 1; m < 3; m++)
    begin
      mode <= 2'(m);
      wr(`ASC_OFF_MODE2, 32'(m));
      in2 <= (m == 1) ? 12'h7ff : 12'hfff;
      cmd(17'sd6000, ASC_SRC_IN2, 1'b0);
    end
    mode <= 2'h0;
    wr(`ASC_OFF_MODE2, 32'h0);
    wr(`ASC_OFF_INSEL, 32'h0b);
    in2 <= 12'h000;
    cmd(-17'sd6000, ASC_SRC_IN2, 1'b1);
    chkrd(`ASC_OFF_STATUS, 32'h2e);
    chkrd(`ASC_OFF_CMD, 32'hffffe890);
    in2 <= `ASC_I4MA;
    cmd(17'sh0, ASC_SRC_IN2, 1'b0);
    wr(`ASC_OFF_ASSIGN, 32'h0);
    chkrd(`ASC_OFF_ASSIGN, 32'h0);
    wr(`ASC_OFF_SAMPLE1, 32'h04);
    wr(`ASC_OFF_GAIN1, gain);
    chkrd(`ASC_OFF_SAMPLE1, 32'h04);
    tl <= 5'h10;
    in2 <= 12'hfff;
    cmd(17'sd6000, ASC_SRC_IN2, 1'b0);
    tl <= 5'h00;
    wr(`ASC_OFF_THERM, 32'd100);
    repeat (6) @(posedge clock);
    `CHK(cmd_source, ASC_SRC_NONE)
    wr(`ASC_OFF_THERM, 32'(`ASC_THERM_OFF));
    repeat (6) @(posedge clock);
    `CHK(cmd_source, ASC_SRC_V1)
    cmd(-17'(gain), ASC_SRC_V1, 1'b1);
    v1 <= 12'h3ff;
    cmd(17'sh0, ASC_SRC_V1, 1'b0);
    complete_run();
  end
endmodule // testbench
